// *** hw/prc_pkg.sv ***
// Constants and state types for the pixel array readout control block
package prc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int PIX_W = 10;
  localparam int GAIN_W = 2;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int WIDE_W = PIX_W + 3;

  // ----------------------------------------------------------------
  // Array geometry and limits
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ROW_LAST = 9'h1FF;
  localparam logic [ADDR_W-1:0] COL_LAST_RESET = 9'h1FF;
  localparam logic [ADDR_W-1:0] PTR_ZERO = 9'h000;
  localparam logic [ADDR_W-1:0] PTR_STEP = 9'h001;
  localparam logic [WIDE_W-1:0] PIX_MAX = 13'h03FF;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [WB_AW-1:0] REG_ROW_START = 8'h00;
  localparam logic [WB_AW-1:0] REG_COL_START = 8'h04;
  localparam logic [WB_AW-1:0] REG_LEFT_PTR = 8'h08;
  localparam logic [WB_AW-1:0] REG_RIGHT_PTR = 8'h0C;
  localparam logic [WB_AW-1:0] REG_COL_PTR = 8'h10;
  localparam logic [WB_AW-1:0] REG_CODE = 8'h14;
  localparam logic [WB_AW-1:0] REG_COL_LAST = 8'h18;
  localparam logic [WB_AW-1:0] REG_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // Byte lanes of the column end register
  // ----------------------------------------------------------------
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 1;
  localparam int BYTE_MSB = 7;
  localparam int ADDR_MSB = ADDR_W - 1;
  localparam int BYTE_W = 8;

  // ----------------------------------------------------------------
  // Register state of the main block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] row_start;
    logic [ADDR_W-1:0] col_start;
    logic [ADDR_W-1:0] left_ptr;
    logic [ADDR_W-1:0] right_ptr;
    logic [ADDR_W-1:0] col_ptr;
    logic [ADDR_W-1:0] col_last;
    logic left_prev;
    logic right_prev;
    logic col_prev;
    logic adc_prev;
    logic left_done_n;
    logic right_done_n;
    logic col_done_n;
    logic row_reset;
    logic row_select;
    logic [ADDR_W-1:0] reset_addr;
    logic [ADDR_W-1:0] select_addr;
    logic amp_s;
    logic amp_r;
    logic pix_valid;
    logic [PIX_W-1:0] amp;
    logic [PIX_W-1:0] conv;
    logic [PIX_W-1:0] code;
    logic code_oe;
    logic ack;
    logic [WB_DW-1:0] rdat;
  } prc_state_t;

endpackage

// *** hw/prc_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
module prc_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Raw pins and filtered levels
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] clean_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] clean;
  } prc_sync_state_t;

  prc_sync_state_t st;
  prc_sync_state_t next_st;

  // Shift chain; a bit changes once stages two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = raw_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Agreeing stages pass on, disagreeing ones keep the old level
    next_st.clean = (st.s2 & st.s3) | (st.clean & (st.s2 | st.s3));
  end

  // State register
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clean_out = st.clean;

endmodule

// *** hw/prc_readout.sv ***
// Pixel array readout control: start latches, pointers, amplifier, converter
// How it works
// - Row reset strobe resets the steered row
// - Row select selects steered row, held high
// - Steering one picks left, zero right
// - One address bus feeds both start latches
// - Row start latch tracks at zero, holds
// - Column start latch tracks at zero, holds
// - Left row pointer steps on falling edge
// - Right row pointer steps on falling edge
// - Left preset low loads row start value
// - Right preset low loads row start value
// - Column preset low loads column start value
// - Pixel output valid while column clock low
// - Calibration gives unity gain dark reference
// - Two gain bits pick x1 x2 x4 x8
// - Converter samples on converter clock falling edge
// - Complement control inverts every output bit
// - Output disable floats converter data outputs
// - Ten-bit result, bit zero least significant
// - Scan done low one period after end
// - Column clock fall steps to next pixel
//
// The implementer's own choices: the Wishbone slave port and the address map.
module prc_readout (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Start address bus and latch controls
  input wire logic [prc_pkg::ADDR_W-1:0] start_addr_in,
  input wire logic row_start_latch_ctl_in,
  input wire logic col_start_latch_ctl_in,
  // Pointer clocks and presets
  input wire logic left_row_shift_clock_in,
  input wire logic left_row_preset_n_in,
  input wire logic right_row_shift_clock_in,
  input wire logic right_row_preset_n_in,
  input wire logic column_shift_clock_in,
  input wire logic column_preset_n_in,
  // Row and column amplifier strobes
  input wire logic row_reset_strobe_in,
  input wire logic row_select_in,
  input wire logic left_right_steer_in,
  input wire logic col_amp_sample_in,
  input wire logic col_amp_reset_in,
  // Amplifier and converter controls
  input wire logic calibrate_in,
  input wire logic gain_select_lsb_in,
  input wire logic gain_select_msb_in,
  input wire logic converter_clock_in,
  input wire logic output_complement_ctl_in,
  input wire logic output_disable_in,
  // Pixel and dark reference levels
  input wire logic [prc_pkg::PIX_W-1:0] pixel_level_in,
  input wire logic [prc_pkg::PIX_W-1:0] dark_level_reference_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [prc_pkg::WB_AW-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [prc_pkg::WB_DW-1:0] wb_dat_in,
  output logic [prc_pkg::WB_DW-1:0] wb_dat_out,
  output logic wb_ack_out,
  // Scan done flags
  output logic left_row_scan_done_n_out,
  output logic right_row_scan_done_n_out,
  output logic column_scan_done_n_out,
  // Pixel array drive
  output logic row_reset_out,
  output logic [prc_pkg::ADDR_W-1:0] row_reset_addr_out,
  output logic row_select_out,
  output logic [prc_pkg::ADDR_W-1:0] row_select_addr_out,
  output logic col_amp_sample_out,
  output logic col_amp_reset_out,
  output logic [prc_pkg::ADDR_W-1:0] pixel_column_out,
  output logic pixel_valid_out,
  output logic [prc_pkg::PIX_W-1:0] amp_level_out,
  // Converter data pins
  output logic [prc_pkg::PIX_W-1:0] pixel_code_out,
  output logic pixel_code_oe_out
);
  import prc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_s;
  logic row_ld_s;
  logic col_ld_s;
  logic left_clk_s;
  logic left_pre_n_s;
  logic right_clk_s;
  logic right_pre_n_s;
  logic col_clk_s;
  logic col_pre_n_s;
  logic reset_s;
  logic select_s;
  logic steer_s;
  logic amp_s_s;
  logic amp_r_s;
  logic cal_s;
  logic [GAIN_W-1:0] gain_s;
  logic adc_clk_s;
  logic inv_s;
  logic tri_s;
  logic [PIX_W-1:0] pix_s;
  logic [PIX_W-1:0] dark_s;
  localparam int SYNC_W = ADDR_W + 2 * PIX_W + GAIN_W + 17;
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_clean;

  // Every sensor pin passes the same filtered chain; the Wishbone pins do not
  assign sync_raw = {start_addr_in, row_start_latch_ctl_in, col_start_latch_ctl_in,
    left_row_shift_clock_in, left_row_preset_n_in, right_row_shift_clock_in,
    right_row_preset_n_in, column_shift_clock_in, column_preset_n_in,
    row_reset_strobe_in, row_select_in, left_right_steer_in, col_amp_sample_in,
    col_amp_reset_in, calibrate_in, gain_select_msb_in, gain_select_lsb_in,
    converter_clock_in, output_complement_ctl_in, output_disable_in,
    pixel_level_in, dark_level_reference_in};
  assign {addr_s, row_ld_s, col_ld_s, left_clk_s, left_pre_n_s, right_clk_s,
    right_pre_n_s, col_clk_s, col_pre_n_s, reset_s, select_s, steer_s, amp_s_s,
    amp_r_s, cal_s, gain_s, adc_clk_s, inv_s, tri_s, pix_s, dark_s} = sync_clean;

  prc_pin_sync #(
    .W(SYNC_W)
  ) u_sync (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .raw_in(sync_raw),
    .clean_out(sync_clean)
  );

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  prc_state_t st;
  prc_state_t next_st;
  logic left_fall;
  logic right_fall;
  logic col_fall;
  logic adc_fall;
  logic [WIDE_W-1:0] gained;
  logic wb_req;

  // Pointer advance with wrap; upper bit is the done flag
  function automatic logic [ADDR_W:0] ptr_step(input logic [ADDR_W-1:0] p,
                                               input logic [ADDR_W-1:0] last);
    if (p == last) begin
      return {1'b0, PTR_ZERO};
    end
    return {1'b1, p + PTR_STEP};
  endfunction

  // Falling edges of the external clocks
  assign left_fall = st.left_prev & ~left_clk_s;
  assign right_fall = st.right_prev & ~right_clk_s;
  assign col_fall = st.col_prev & ~col_clk_s;
  assign adc_fall = st.adc_prev & ~adc_clk_s;
  assign wb_req = wb_cyc_in & wb_stb_in & ~st.ack;

  // Gain by left shift, clipped at full scale
  assign gained = WIDE_W'({3'h0, pix_s} << gain_s);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.left_prev = left_clk_s;
    next_st.right_prev = right_clk_s;
    next_st.col_prev = col_clk_s;
    next_st.adc_prev = adc_clk_s;

    // Start latches share the bus, each by its own control
    if (!row_ld_s) begin
      next_st.row_start = addr_s;
    end
    if (!col_ld_s) begin
      next_st.col_start = addr_s;
    end

    // Left row pointer: preset wins, else step on fall
    if (!left_pre_n_s) begin
      next_st.left_ptr = st.row_start;
      next_st.left_done_n = 1'b1;
    end else if (left_fall) begin
      {next_st.left_done_n, next_st.left_ptr} = ptr_step(st.left_ptr, ROW_LAST);
    end

    // Right row pointer
    if (!right_pre_n_s) begin
      next_st.right_ptr = st.row_start;
      next_st.right_done_n = 1'b1;
    end else if (right_fall) begin
      {next_st.right_done_n, next_st.right_ptr} = ptr_step(st.right_ptr, ROW_LAST);
    end

    // Column pointer ends at the programmed last column
    if (!col_pre_n_s) begin
      next_st.col_ptr = st.col_start;
      next_st.col_done_n = 1'b1;
    end else if (col_fall) begin
      {next_st.col_done_n, next_st.col_ptr} = ptr_step(st.col_ptr, st.col_last);
    end

    // Row strobes follow the steered pointer
    next_st.row_reset = reset_s;
    next_st.reset_addr = steer_s ? st.left_ptr : st.right_ptr;
    next_st.row_select = select_s;
    next_st.select_addr = steer_s ? st.left_ptr : st.right_ptr;
    next_st.amp_s = amp_s_s;
    next_st.amp_r = amp_r_s;

    // Output stage tracks while column clock high, holds while low, unless calibrating
    next_st.pix_valid = ~col_clk_s;
    if (cal_s) begin
      next_st.amp = dark_s;
    end else if (col_clk_s) begin
      next_st.amp = (gained > PIX_MAX) ? PIX_MAX[PIX_W-1:0] : gained[PIX_W-1:0];
    end

    // Converter samples the amplifier level on its clock fall
    if (adc_fall) begin
      next_st.conv = st.amp;
    end
    next_st.code = inv_s ? ~st.conv : st.conv;
    next_st.code_oe = ~tri_s;

    // Wishbone: one-cycle answer, ack drops the next cycle
    next_st.ack = wb_req;
    next_st.rdat = '0;
    if (wb_req && wb_we_in && wb_adr_in == REG_COL_LAST) begin
      if (wb_sel_in[LANE_LO]) begin
        next_st.col_last[BYTE_MSB:0] = wb_dat_in[BYTE_MSB:0];
      end
      if (wb_sel_in[LANE_HI]) begin
        next_st.col_last[ADDR_MSB] = wb_dat_in[BYTE_W];
      end
    end
    if (wb_req && !wb_we_in) begin
      case (wb_adr_in)
        REG_ROW_START: next_st.rdat = WB_DW'(st.row_start);
        REG_COL_START: next_st.rdat = WB_DW'(st.col_start);
        REG_LEFT_PTR: next_st.rdat = WB_DW'(st.left_ptr);
        REG_RIGHT_PTR: next_st.rdat = WB_DW'(st.right_ptr);
        REG_COL_PTR: next_st.rdat = WB_DW'(st.col_ptr);
        REG_CODE: next_st.rdat = WB_DW'(st.conv);
        REG_COL_LAST: next_st.rdat = WB_DW'(st.col_last);
        REG_STATUS: next_st.rdat = WB_DW'({steer_s, st.code_oe, st.pix_valid,
                                           st.col_done_n, st.right_done_n, st.left_done_n});
        default: next_st.rdat = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st <= '0;
      st.col_last <= COL_LAST_RESET;
      st.left_done_n <= 1'b1;
      st.right_done_n <= 1'b1;
      st.col_done_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_out = st.rdat;
  assign wb_ack_out = st.ack;
  assign left_row_scan_done_n_out = st.left_done_n;
  assign right_row_scan_done_n_out = st.right_done_n;
  assign column_scan_done_n_out = st.col_done_n;
  assign row_reset_out = st.row_reset;
  assign row_reset_addr_out = st.reset_addr;
  assign row_select_out = st.row_select;
  assign row_select_addr_out = st.select_addr;
  assign col_amp_sample_out = st.amp_s;
  assign col_amp_reset_out = st.amp_r;
  assign pixel_column_out = st.col_ptr;
  assign pixel_valid_out = st.pix_valid;
  assign amp_level_out = st.amp;
  assign pixel_code_out = st.code;
  assign pixel_code_oe_out = st.code_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  sequence left_step_s;
    left_fall && left_pre_n_s && st.left_ptr != ROW_LAST;
  endsequence
  sequence left_end_s;
    left_fall && left_pre_n_s && st.left_ptr == ROW_LAST;
  endsequence

  row_reset_steer_a: assert property (reset_s && steer_s |=> row_reset_out &&
    row_reset_addr_out == $past(st.left_ptr)) else $error("reset not steered left");
  row_select_right_a: assert property (select_s && !steer_s |=> row_select_out &&
    row_select_addr_out == $past(st.right_ptr)) else $error("select not steered right");
  row_latch_hold_a: assert property (row_ld_s && $past(row_ld_s) |-> $stable(st.row_start))
    else $error("row start moved while held");
  col_latch_track_a: assert property (!col_ld_s |=> st.col_start == $past(addr_s))
    else $error("column start did not track bus");
  left_step_a: assert property (left_step_s |=> st.left_ptr == $past(st.left_ptr) + PTR_STEP)
    else $error("left pointer did not step");
  right_rise_a: assert property (!st.right_prev && right_clk_s && right_pre_n_s |=>
    $stable(st.right_ptr)) else $error("right pointer moved on rising edge");
  left_preset_a: assert property (!left_pre_n_s |=> st.left_ptr == $past(st.row_start))
    else $error("left preset did not load");
  col_preset_a: assert property (!col_pre_n_s ##1 !col_pre_n_s |-> st.col_ptr == $past(st.col_start))
    else $error("column preset did not load");
  hold_low_a: assert property (!col_clk_s && !cal_s |=> $stable(st.amp))
    else $error("output moved while column clock low");
  cal_dark_a: assert property (cal_s |=> amp_level_out == $past(dark_s))
    else $error("calibration level wrong");
  code_invert_a: assert property (inv_s |=> pixel_code_out == ~$past(st.conv))
    else $error("code not complemented");
  code_float_a: assert property (tri_s |=> !pixel_code_oe_out) else $error("data driven while disabled");
  scan_done_a: assert property (left_end_s |=> !left_row_scan_done_n_out && st.left_ptr == PTR_ZERO)
    else $error("left scan done pulse missing");

  // Right preset, column steps, converter sample, row select and gain path
  right_preset_a: assert property (!right_pre_n_s |=> st.right_ptr == $past(st.row_start))
    else $error("right preset did not load");
  col_step_a: assert property (col_fall && col_pre_n_s && st.col_ptr != st.col_last |=>
    pixel_column_out == $past(st.col_ptr) + PTR_STEP) else $error("column did not step");
  col_done_a: assert property (col_fall && col_pre_n_s && st.col_ptr == st.col_last |=>
    !column_scan_done_n_out) else $error("column scan done pulse missing");
  conv_sample_a: assert property (adc_fall |=> st.conv == $past(st.amp))
    else $error("converter did not sample");
  select_follow_a: assert property (select_s |=> row_select_out)
    else $error("row select not passed on");
  unity_gain_a: assert property (col_clk_s && !cal_s && gain_s == '0 |=>
    amp_level_out == $past(pix_s)) else $error("unity gain level wrong");

endmodule

// *** testbench/prc_ctl.sv ***
// Timing controller model driving the sensor control pins
module prc_ctl (
  // Clock
  input wire logic mclk_in,
  // Start address and latch controls
  output logic [prc_pkg::ADDR_W-1:0] addr_out,
  output logic rlat_out,
  output logic clat_out,
  // Pointer clocks and presets: 0 left, 1 right, 2 column
  output logic [2:0] sclk_out,
  output logic [2:0] pre_n_out,
  // Row strobes, amplifier and converter controls
  output logic rst_out,
  output logic sel_out,
  output logic steer_out,
  output logic ams_out,
  output logic amr_out,
  output logic cal_out,
  output logic [1:0] gain_out,
  output logic aclk_out,
  output logic cmp_out,
  output logic dis_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import prc_pkg::*;
  int hold = 8; // Clocks per level, above the input filter
  // Idle levels, pointer clocks high so presets are legal
  initial begin
    addr_out = PTR_ZERO;
    rlat_out = 1'b1;
    clat_out = 1'b1;
    sclk_out = 3'h7;
    pre_n_out = 3'h7;
    rst_out = 1'b0;
    sel_out = 1'b1;
    steer_out = 1'b0;
    ams_out = 1'b0;
    amr_out = 1'b0;
    cal_out = 1'b0;
    gain_out = 2'h0;
    aclk_out = 1'b1;
    cmp_out = 1'b0;
    dis_out = 1'b0;
  end
  // Hold the present levels
  task automatic settle();
    repeat (hold) @(posedge mclk_in);
  endtask
  // Load a start latch ahead of any preset, then move the bus on
  task automatic load(input logic col, input logic [ADDR_W-1:0] a);
    addr_out <= a;
    clat_out <= ~col;
    rlat_out <= col;
    settle();
    clat_out <= 1'b1;
    rlat_out <= 1'b1;
    addr_out <= ~a;
    settle();
  endtask
  // Preset pulse, given only while that clock is high
  task automatic preset(input int i);
    pre_n_out[i] <= 1'b0;
    settle();
    pre_n_out[i] <= 1'b1;
    settle();
  endtask
  // One level change on a pointer clock
  task automatic sclk(input int i, input logic v);
    sclk_out[i] <= v;
    settle();
  endtask
  // Converter clock falling edge, then back high
  task automatic conv();
    aclk_out <= 1'b0;
    settle();
    aclk_out <= 1'b1;
    settle();
  endtask
endmodule

// *** testbench/prc_readout_bench.sv ***
// Self-checking bench for the pixel array readout control block
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module prc_readout_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import prc_pkg::*;
  logic mclk_in = 1'b0, reset_in = 1'b1;
  logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [WB_AW-1:0] wb_adr_in = '0;
  logic [3:0] wb_sel_in = 4'hF;
  logic [WB_DW-1:0] wb_dat_in = '0, wb_dat_out;
  logic [PIX_W-1:0] pix = 10'h0C8, dark = 10'h2A5, amp_level_out, pixel_code_out;
  logic wb_ack_out, left_row_scan_done_n_out, right_row_scan_done_n_out, column_scan_done_n_out;
  logic row_reset_out, row_select_out, col_amp_sample_out, col_amp_reset_out, pixel_valid_out, pixel_code_oe_out;
  logic [ADDR_W-1:0] addr, row_reset_addr_out, row_select_addr_out, pixel_column_out;
  logic rlat, clat, rst, sel, steer, ams, amr, cal, aclk, cmp, dis;
  logic [2:0] sclk, pre;
  logic [1:0] gain;
  int mismatches = 0, checked = 0;
  // Clock
  always #2 mclk_in = ~mclk_in;
  prc_ctl prc_ctl_i (.mclk_in, .addr_out(addr), .rlat_out(rlat), .clat_out(clat), .sclk_out(sclk),
    .pre_n_out(pre), .rst_out(rst), .sel_out(sel), .steer_out(steer), .ams_out(ams), .amr_out(amr),
    .cal_out(cal), .gain_out(gain), .aclk_out(aclk), .cmp_out(cmp), .dis_out(dis));
  prc_readout prc_readout_i (.mclk_in, .reset_in, .start_addr_in(addr), .row_start_latch_ctl_in(rlat),
    .col_start_latch_ctl_in(clat), .left_row_shift_clock_in(sclk[0]), .left_row_preset_n_in(pre[0]),
    .right_row_shift_clock_in(sclk[1]), .right_row_preset_n_in(pre[1]), .column_shift_clock_in(sclk[2]),
    .column_preset_n_in(pre[2]), .row_reset_strobe_in(rst), .row_select_in(sel), .left_right_steer_in(steer),
    .col_amp_sample_in(ams), .col_amp_reset_in(amr), .calibrate_in(cal), .gain_select_lsb_in(gain[0]),
    .gain_select_msb_in(gain[1]), .converter_clock_in(aclk), .output_complement_ctl_in(cmp),
    .output_disable_in(dis), .pixel_level_in(pix), .dark_level_reference_in(dark), .wb_cyc_in, .wb_stb_in,
    .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .left_row_scan_done_n_out,
    .right_row_scan_done_n_out, .column_scan_done_n_out, .row_reset_out, .row_reset_addr_out,
    .row_select_out, .row_select_addr_out, .col_amp_sample_out, .col_amp_reset_out, .pixel_column_out,
    .pixel_valid_out, .amp_level_out, .pixel_code_out, .pixel_code_oe_out);
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                    output logic [31:0] q);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_sel_in <= s;
    wb_dat_in <= d;
    do begin
      @(posedge mclk_in);
    end while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  // Register read and compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    wb(1'b0, a, 4'hF, 32'h0, q);
    `CHK(nm, e, q)
  endtask
  // Start latches share the bus, writes to them are ignored
  task automatic t_latch();
    logic [31:0] q;
    prc_ctl_i.load(1'b0, 9'h1A5);
    prc_ctl_i.load(1'b1, 9'h05A);
    wb(1'b1, REG_ROW_START, 4'hF, 32'h0, q);
    rd(REG_ROW_START, 32'h1A5, "row start");
    rd(REG_COL_START, 32'h05A, "col start");
    rd(8'h20, 32'h0, "unmapped");
  endtask
  // Row pointers: preset, falling steps, steering of strobes
  task automatic t_rows();
    prc_ctl_i.preset(0);
    prc_ctl_i.preset(1);
    rd(REG_RIGHT_PTR, 32'h1A5, "right preset");
    prc_ctl_i.sclk(0, 1'b0);
    prc_ctl_i.sclk(0, 1'b1);
    rd(REG_LEFT_PTR, 32'h1A6, "left step");
    prc_ctl_i.sclk(1, 1'b0);
    prc_ctl_i.sclk(1, 1'b1);
    prc_ctl_i.sclk(1, 1'b0);
    prc_ctl_i.sclk(1, 1'b1);
    rd(REG_RIGHT_PTR, 32'h1A7, "right step");
    prc_ctl_i.rst_out <= 1'b1;
    prc_ctl_i.steer_out <= 1'b1;
    prc_ctl_i.ams_out <= 1'b1;
    prc_ctl_i.settle();
    `CHK("reset row", 10'h3A6, {row_reset_out, row_reset_addr_out})
    `CHK("select row", 10'h3A6, {row_select_out, row_select_addr_out})
    `CHK("amp strobe", 2'h2, {col_amp_sample_out, col_amp_reset_out})
    prc_ctl_i.steer_out <= 1'b0;
    prc_ctl_i.ams_out <= 1'b0;
    prc_ctl_i.settle();
    `CHK("reset right", 10'h3A7, {row_reset_out, row_reset_addr_out})
    prc_ctl_i.rst_out <= 1'b0;
    prc_ctl_i.settle();
    `CHK("reset off", 1'b0, row_reset_out)
  endtask
  // End of scan on the last row and on the last active column
  task automatic t_scan_end();
    logic [31:0] q;
    prc_ctl_i.load(1'b0, ROW_LAST);
    prc_ctl_i.preset(0);
    prc_ctl_i.sclk(0, 1'b0);
    `CHK("left done", 1'b0, left_row_scan_done_n_out)
    rd(REG_LEFT_PTR, 32'h0, "left wrap");
    prc_ctl_i.sclk(0, 1'b1);
    prc_ctl_i.sclk(0, 1'b0);
    `CHK("left done off", 1'b1, left_row_scan_done_n_out)
    wb(1'b1, REG_COL_LAST, 4'h1, 32'h3, q);
    rd(REG_COL_LAST, 32'h103, "col last lane");
    wb(1'b1, REG_COL_LAST, 4'h3, 32'h3, q);
    prc_ctl_i.load(1'b1, 9'h002);
    prc_ctl_i.preset(2);
    `CHK("col preset", 9'h002, pixel_column_out)
    rd(REG_COL_PTR, 32'h002, "col ptr reg");
    prc_ctl_i.sclk(2, 1'b0);
    `CHK("col step", 9'h003, pixel_column_out)
    prc_ctl_i.sclk(2, 1'b1);
    prc_ctl_i.sclk(2, 1'b0);
    `CHK("col done", 1'b0, column_scan_done_n_out)
    prc_ctl_i.sclk(2, 1'b1);
    rd(REG_STATUS, 32'h13, "status");
  endtask
  // Gain codes, hold, calibration, converter controls
  task automatic t_amp();
    logic [WIDE_W-1:0] e;
    prc_ctl_i.hold = 12;
    for (int g = 0; g < 4; g++) begin
      prc_ctl_i.gain_out <= g[1:0];
      prc_ctl_i.settle();
      e = WIDE_W'(pix) << g;
      if (e > PIX_MAX) e = PIX_MAX;
      `CHK("gain", e[PIX_W-1:0], amp_level_out)
    end
    prc_ctl_i.gain_out <= 2'h2;
    prc_ctl_i.settle();
    prc_ctl_i.sclk(2, 1'b0);
    `CHK("valid low", 1'b1, pixel_valid_out)
    pix <= 10'h011;
    prc_ctl_i.conv();
    `CHK("code", 10'h320, pixel_code_out)
    rd(REG_CODE, 32'h320, "code reg");
    prc_ctl_i.cmp_out <= 1'b1;
    prc_ctl_i.conv();
    `CHK("code inv", 10'h0DF, pixel_code_out)
    prc_ctl_i.dis_out <= 1'b1;
    prc_ctl_i.settle();
    `CHK("code oe", 1'b0, pixel_code_oe_out)
    prc_ctl_i.dis_out <= 1'b0;
    prc_ctl_i.cal_out <= 1'b1;
    prc_ctl_i.settle();
    `CHK("dark", dark, amp_level_out)
    `CHK("code oe on", 1'b1, pixel_code_oe_out)
    prc_ctl_i.cal_out <= 1'b0;
    prc_ctl_i.sclk(2, 1'b1);
    `CHK("valid high", 1'b0, pixel_valid_out)
  endtask
  // Verdict and end of run
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    prc_ctl_i.settle();
    `CHK("done flags", 3'h7, {left_row_scan_done_n_out, right_row_scan_done_n_out, column_scan_done_n_out})
    rd(REG_COL_LAST, 32'h1FF, "col last reset");
    t_latch();
    t_rows();
    t_scan_end();
    t_amp();
    end_of_test();
  end
endmodule
